//--- design/bsil_pkg.sv
// shared constants and types for the boundary-scan instruction logic
package bsil_pkg;

  // ****************************************
  // tap controller states and host commands
  // ****************************************
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } bsil_tap_t;

  typedef enum logic [1:0] {
    CMD_RESET, CMD_IR, CMD_DR
  } bsil_cmd_t;

  // ****************************************
  // register sizes and codes
  // ****************************************
  localparam int IR_LEN   = 3;
  localparam int ID_LEN   = 32;
  localparam int PIN_CNT  = 108;
  localparam int BSR_LEN  = 109;
  localparam int OE_CELL  = 108;

  localparam logic [2:0] IR_EXTEST   = 3'h0;
  localparam logic [2:0] IR_IDENT    = 3'h1;
  localparam logic [2:0] IR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] IR_SAMPLE   = 3'h4;
  localparam logic [2:0] IR_BYPASS   = 3'h7;
  localparam logic [2:0] IR_CAPTURE  = 3'h1;

  localparam logic [BSR_LEN-1:0] BSR_LATCH_RST = {1'h1, {PIN_CNT{1'h0}}};

  // ****************************************
  // timing
  // ****************************************
  localparam int RESET_TMS_HIGH    = 5;
  localparam int TCK_MAX_MHZ       = 20;
  localparam int TCK_MIN_PERIOD_NS = 1000 / TCK_MAX_MHZ;
  localparam int SYS_PERIOD_NS     = 40;
  localparam int TCK_HALF_MIN_CYC  = (TCK_MIN_PERIOD_NS / 2 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int TCK_HALF_DEF_CYC  = 4;

endpackage : bsil_pkg

//--- design/bsil_if.sv
// serial test link between the test controller and the device
`timescale 1ns/1ps
interface bsil_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;

  modport ctl (output tck, output tms, output tdi, input tdo, input tdo_oe);
  modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
endinterface : bsil_if

//--- design/bsil_tap_fsm.sv
// sixteen-state tap controller, advanced once per step pulse
`timescale 1ns/1ps
module bsil_tap_fsm (
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rstn_in,
  // one step per rising test clock edge
  input  wire logic              step_in,
  input  wire logic              tms_in,
  // current state
  output bsil_pkg::bsil_tap_t    state_out
);

  bsil_pkg::bsil_tap_t state_r;
  bsil_pkg::bsil_tap_t state_nxt;
  bsil_pkg::bsil_tap_t walk;

  always_comb begin
    unique case (state_r)
      bsil_pkg::TAP_RESET:  walk = tms_in ? bsil_pkg::TAP_RESET  : bsil_pkg::TAP_IDLE;
      bsil_pkg::TAP_IDLE:   walk = tms_in ? bsil_pkg::TAP_SEL_DR : bsil_pkg::TAP_IDLE;
      bsil_pkg::TAP_SEL_DR: walk = tms_in ? bsil_pkg::TAP_SEL_IR : bsil_pkg::TAP_CAP_DR;
      bsil_pkg::TAP_CAP_DR: walk = tms_in ? bsil_pkg::TAP_EX1_DR : bsil_pkg::TAP_SH_DR;
      bsil_pkg::TAP_SH_DR:  walk = tms_in ? bsil_pkg::TAP_EX1_DR : bsil_pkg::TAP_SH_DR;
      bsil_pkg::TAP_EX1_DR: walk = tms_in ? bsil_pkg::TAP_UPD_DR : bsil_pkg::TAP_PAU_DR;
      bsil_pkg::TAP_PAU_DR: walk = tms_in ? bsil_pkg::TAP_EX2_DR : bsil_pkg::TAP_PAU_DR;
      bsil_pkg::TAP_EX2_DR: walk = tms_in ? bsil_pkg::TAP_UPD_DR : bsil_pkg::TAP_SH_DR;
      bsil_pkg::TAP_UPD_DR: walk = tms_in ? bsil_pkg::TAP_SEL_DR : bsil_pkg::TAP_IDLE;
      bsil_pkg::TAP_SEL_IR: walk = tms_in ? bsil_pkg::TAP_RESET  : bsil_pkg::TAP_CAP_IR;
      bsil_pkg::TAP_CAP_IR: walk = tms_in ? bsil_pkg::TAP_EX1_IR : bsil_pkg::TAP_SH_IR;
      bsil_pkg::TAP_SH_IR:  walk = tms_in ? bsil_pkg::TAP_EX1_IR : bsil_pkg::TAP_SH_IR;
      bsil_pkg::TAP_EX1_IR: walk = tms_in ? bsil_pkg::TAP_UPD_IR : bsil_pkg::TAP_PAU_IR;
      bsil_pkg::TAP_PAU_IR: walk = tms_in ? bsil_pkg::TAP_EX2_IR : bsil_pkg::TAP_PAU_IR;
      bsil_pkg::TAP_EX2_IR: walk = tms_in ? bsil_pkg::TAP_UPD_IR : bsil_pkg::TAP_SH_IR;
      bsil_pkg::TAP_UPD_IR: walk = tms_in ? bsil_pkg::TAP_SEL_DR : bsil_pkg::TAP_IDLE;
    endcase
  end

  // five high tms steps reach reset from any state
  assign state_nxt = step_in ? walk : state_r;
  assign state_out = state_r;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state_r <= bsil_pkg::TAP_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

endmodule : bsil_tap_fsm

//--- design/bsil_dev.sv
// device end: tap instruction decode, data register selection and boundary cells
// Function
// - identification instruction captures and shifts 32-bit value
// - three-bit instruction register, five codes used
// - shifted instruction takes effect at Update-IR
// - reset and Test-Logic-Reset select identification
// - identification value drives serial out in Shift-DR
// - sample-high-Z shifts boundary, floats memory outputs
// - sample/preload captures all pin levels
// - controller keeps pins stable around capture
// - shift captured data out, preload data in
// - preload lands in latch, memory unaffected
// - bypass puts one-bit register in path
// - external test drives latched values onto pins
// - cell 108 latched, gates output drivers
// - controller programs cell 108 via Update-DR
// - cell 108 latch presets to one
// - controller never loads reserved instruction codes
// - test clock at most 20 MHz
// - sample on rising, serial out on falling
// - Capture-IR loads 01 into low bits
// - five high mode-select edges reset test logic
// - instruction code assignments, three codes reserved
`timescale 1ns/1ps
module bsil_dev #(
  // arbitrary neutral identification value, bit 0 marks an id register
  parameter logic [31:0] ID_VALUE = 32'h0123_4567
) (
  // clock and reset
  input  wire logic                         clk_sys_in,
  input  wire logic                         rstn_in,
  // serial test link
  bsil_if.dev                               link,
  // memory pins seen by the boundary cells
  input  wire logic [bsil_pkg::PIN_CNT-1:0] pin_levels_in,
  // boundary drive to the memory pins
  output logic      [bsil_pkg::PIN_CNT-1:0] preload_out,
  output logic                              extest_drive_out,
  output logic                              out_bus_oe_out,
  output logic      [bsil_pkg::IR_LEN-1:0]  instr_out
);

  // ****************************************
  // link synchronisers
  // ****************************************
  logic tck_s1_r;
  logic tck_s2_r;
  logic tck_s3_r;
  logic tms_s1_r;
  logic tms_s2_r;
  logic tdi_s1_r;
  logic tdi_s2_r;
  logic [bsil_pkg::PIN_CNT-1:0] pin_s1_r;
  logic [bsil_pkg::PIN_CNT-1:0] pin_s2_r;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      tck_s1_r <= 1'h0;
      tck_s2_r <= 1'h0;
      tck_s3_r <= 1'h0;
      tms_s1_r <= 1'h1;
      tms_s2_r <= 1'h1;
      tdi_s1_r <= 1'h1;
      tdi_s2_r <= 1'h1;
    end else begin
      tck_s1_r <= link.tck;
      tck_s2_r <= tck_s1_r;
      tck_s3_r <= tck_s2_r;
      tms_s1_r <= link.tms;
      tms_s2_r <= tms_s1_r;
      tdi_s1_r <= link.tdi;
      tdi_s2_r <= tdi_s1_r;
    end
  end

  // pins only need two stages; their levels are captured, not interpreted
  always_ff @(posedge clk_sys_in) begin
    pin_s1_r <= pin_levels_in;
    pin_s2_r <= pin_s1_r;
  end

  // tms and tdi are delayed as much as tck, so they are read as of the rise
  wire rise = tck_s2_r & ~tck_s3_r;
  wire fall = ~tck_s2_r & tck_s3_r;

  // ****************************************
  // tap controller
  // ****************************************
  bsil_pkg::bsil_tap_t st;

  bsil_tap_fsm u_fsm (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .step_in    (rise),
    .tms_in     (tms_s2_r),
    .state_out  (st)
  );

  wire in_reset = (st == bsil_pkg::TAP_RESET);
  wire cap_ir   = rise && (st == bsil_pkg::TAP_CAP_IR);
  wire sh_ir    = rise && (st == bsil_pkg::TAP_SH_IR);
  wire upd_ir   = rise && (st == bsil_pkg::TAP_UPD_IR);
  wire cap_dr   = rise && (st == bsil_pkg::TAP_CAP_DR);
  wire sh_dr    = rise && (st == bsil_pkg::TAP_SH_DR);
  wire upd_dr   = rise && (st == bsil_pkg::TAP_UPD_DR);

  // ****************************************
  // instruction register
  // ****************************************
  logic [bsil_pkg::IR_LEN-1:0] ir_sh_r;
  logic [bsil_pkg::IR_LEN-1:0] ir_sh_nxt;
  logic [bsil_pkg::IR_LEN-1:0] ir_r;
  logic [bsil_pkg::IR_LEN-1:0] ir_nxt;

  assign ir_sh_nxt = cap_ir ? bsil_pkg::IR_CAPTURE :
                     sh_ir  ? {tdi_s2_r, ir_sh_r[bsil_pkg::IR_LEN-1:1]} :
                              ir_sh_r;
  // the shifted code only becomes current at update; reset forces identification
  assign ir_nxt = in_reset ? bsil_pkg::IR_IDENT :
                  upd_ir   ? ir_sh_r :
                             ir_r;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ir_sh_r <= bsil_pkg::IR_CAPTURE;
      ir_r    <= bsil_pkg::IR_IDENT;
    end else begin
      ir_sh_r <= ir_sh_nxt;
      ir_r    <= ir_nxt;
    end
  end

  // ****************************************
  // instruction decode
  // ****************************************
  // reserved codes fall through to the bypass path, keeping the chain intact
  wire sel_ident = (ir_r == bsil_pkg::IR_IDENT);
  wire sel_hiz   = (ir_r == bsil_pkg::IR_SAMPLE_Z);
  wire sel_ext   = (ir_r == bsil_pkg::IR_EXTEST);
  wire sel_bsr   = sel_ext | sel_hiz | (ir_r == bsil_pkg::IR_SAMPLE);
  wire sel_byp   = ~sel_ident & ~sel_bsr;

  // ****************************************
  // data registers
  // ****************************************
  logic [bsil_pkg::ID_LEN-1:0]  id_sh_r;
  logic [bsil_pkg::ID_LEN-1:0]  id_sh_nxt;
  logic                         byp_r;
  logic                         byp_nxt;
  logic [bsil_pkg::BSR_LEN-1:0] bsr_sh_r;
  logic [bsil_pkg::BSR_LEN-1:0] bsr_sh_nxt;
  logic [bsil_pkg::BSR_LEN-1:0] latch_r;
  logic [bsil_pkg::BSR_LEN-1:0] latch_nxt;

  assign id_sh_nxt = (cap_dr && sel_ident) ? ID_VALUE :
                     (sh_dr && sel_ident)  ? {tdi_s2_r, id_sh_r[bsil_pkg::ID_LEN-1:1]} :
                                             id_sh_r;

  assign byp_nxt = (cap_dr && sel_byp) ? 1'h0 :
                   (sh_dr && sel_byp)  ? tdi_s2_r :
                                         byp_r;

  // the tristate cell captures its own latched value, having no pin behind it
  assign bsr_sh_nxt = (cap_dr && sel_bsr) ? {latch_r[bsil_pkg::OE_CELL], pin_s2_r} :
                      (sh_dr && sel_bsr)  ? {tdi_s2_r, bsr_sh_r[bsil_pkg::BSR_LEN-1:1]} :
                                            bsr_sh_r;

  wire latch_upd = upd_dr && sel_bsr;
  assign latch_nxt[bsil_pkg::PIN_CNT-1:0] = latch_upd ? bsr_sh_r[bsil_pkg::PIN_CNT-1:0] :
                                                        latch_r[bsil_pkg::PIN_CNT-1:0];
  assign latch_nxt[bsil_pkg::OE_CELL] = in_reset  ? 1'h1 :
                                        latch_upd ? bsr_sh_r[bsil_pkg::OE_CELL] :
                                                    latch_r[bsil_pkg::OE_CELL];

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      id_sh_r  <= '0;
      byp_r    <= 1'h0;
      bsr_sh_r <= '0;
      latch_r  <= bsil_pkg::BSR_LATCH_RST;
    end else begin
      id_sh_r  <= id_sh_nxt;
      byp_r    <= byp_nxt;
      bsr_sh_r <= bsr_sh_nxt;
      latch_r  <= latch_nxt;
    end
  end

  // ****************************************
  // serial output, changed on the falling test clock edge
  // ****************************************
  logic tdo_r;
  logic tdo_nxt;
  logic tdo_oe_r;
  logic tdo_oe_nxt;

  wire shifting = (st == bsil_pkg::TAP_SH_IR) || (st == bsil_pkg::TAP_SH_DR);
  wire dr_lsb   = sel_ident ? id_sh_r[0] : sel_bsr ? bsr_sh_r[0] : byp_r;
  wire path_lsb = (st == bsil_pkg::TAP_SH_IR) ? ir_sh_r[0] : dr_lsb;

  assign tdo_nxt    = (fall && shifting) ? path_lsb : tdo_r;
  assign tdo_oe_nxt = fall ? shifting : tdo_oe_r;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      tdo_r    <= 1'h0;
      tdo_oe_r <= 1'h0;
    end else begin
      tdo_r    <= tdo_nxt;
      tdo_oe_r <= tdo_oe_nxt;
    end
  end

  assign link.tdo    = tdo_r;
  assign link.tdo_oe = tdo_oe_r;

  // ****************************************
  // drive toward the memory pins
  // ****************************************
  // sample/preload and identification leave the memory outputs alone
  logic ext_r;
  logic oe_r;
  wire  oe_nxt = sel_hiz ? 1'h0 :
                 sel_ext ? latch_r[bsil_pkg::OE_CELL] :
                           1'h1;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ext_r <= 1'h0;
      oe_r  <= 1'h1;
    end else begin
      ext_r <= sel_ext;
      oe_r  <= oe_nxt;
    end
  end

  assign preload_out      = latch_r[bsil_pkg::PIN_CNT-1:0];
  assign extest_drive_out = ext_r;
  assign out_bus_oe_out   = oe_r;
  assign instr_out        = ir_r;

endmodule : bsil_dev

//--- design/bsil_ctl.sv
// controller end: drives the test clock and walks scans through the tap
`timescale 1ns/1ps
module bsil_ctl #(
  parameter int HALF_CYC = bsil_pkg::TCK_HALF_DEF_CYC,
  parameter int DW       = 128
) (
  // clock and reset
  input  wire logic                clk_sys_in,
  input  wire logic                rstn_in,
  // command from the user
  input  wire logic                cmd_valid_in,
  input  wire bsil_pkg::bsil_cmd_t cmd_kind_in,
  input  wire logic [7:0]          cmd_len_in,
  input  wire logic [DW-1:0]       cmd_data_in,
  output logic                     cmd_ready_out,
  // answer to the user
  output logic                     rsp_valid_out,
  output logic                     rsp_err_out,
  output logic [DW-1:0]            rsp_data_out,
  // serial test link
  bsil_if.ctl                      link
);

  // never faster than the device allows
  localparam int HALF = (HALF_CYC < bsil_pkg::TCK_HALF_MIN_CYC) ? bsil_pkg::TCK_HALF_MIN_CYC : HALF_CYC;
  localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

  typedef enum logic [1:0] {C_IDLE, C_RUN, C_DONE} bsil_ctl_t;

  // ****************************************
  // tdo synchroniser
  // ****************************************
  logic tdo_s1_r;
  logic tdo_s2_r;

  always_ff @(posedge clk_sys_in) begin
    tdo_s1_r <= link.tdo;
    tdo_s2_r <= tdo_s1_r;
  end

  // ****************************************
  // test clock divider and tap tracking
  // ****************************************
  bsil_ctl_t           cs_r;
  bsil_pkg::bsil_tap_t st;
  logic [7:0]          div_r;
  logic                tck_r;
  logic                tms_r;
  logic                tdi_r;
  logic                taken_r;
  logic                fin_r;
  logic [7:0]          rcnt_r;
  logic [7:0]          len_r;
  bsil_pkg::bsil_cmd_t kind_r;
  logic [DW-1:0]       sh_r;
  logic                rdy_r;
  logic                rv_r;
  logic                re_r;
  logic [DW-1:0]       rd_r;

  wire run  = (cs_r == C_RUN);
  wire tick = run && (div_r == HALF_LAST);
  wire rise = tick && !tck_r;
  wire fall = tick && tck_r;

  bsil_tap_fsm u_fsm (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .step_in    (rise),
    .tms_in     (tms_r),
    .state_out  (st)
  );

  wire in_shift  = (st == bsil_pkg::TAP_SH_IR) || (st == bsil_pkg::TAP_SH_DR);
  wire is_reset  = (kind_r == bsil_pkg::CMD_RESET);
  wire cnt_rise  = rise && (is_reset || in_shift);
  wire last_rise = is_reset ? (rcnt_r == 8'(bsil_pkg::RESET_TMS_HIGH))
                            : ((st == bsil_pkg::TAP_UPD_IR) || (st == bsil_pkg::TAP_UPD_DR));

  // mode select path: idle -> select -> capture -> shift -> exit1 -> update -> idle
  logic tms_nxt;
  always_comb begin
    unique case (st)
      bsil_pkg::TAP_IDLE:   tms_nxt = ~is_reset;
      bsil_pkg::TAP_SEL_DR: tms_nxt = (kind_r == bsil_pkg::CMD_IR);
      bsil_pkg::TAP_SH_IR,
      bsil_pkg::TAP_SH_DR:  tms_nxt = (rcnt_r == len_r - 8'h01);
      bsil_pkg::TAP_EX1_IR,
      bsil_pkg::TAP_EX1_DR: tms_nxt = 1'h1;
      default:              tms_nxt = 1'h0;
    endcase
  end

  wire [DW-1:0] sh_in   = {tdo_s2_r, sh_r[DW-1:1]};
  wire          tms_rst = (rcnt_r < 8'(bsil_pkg::RESET_TMS_HIGH));
  wire          reserved = (cmd_data_in[2:0] == 3'h3) || (cmd_data_in[2:0] == 3'h5) || (cmd_data_in[2:0] == 3'h6);
  wire          refuse   = (cmd_kind_in == bsil_pkg::CMD_IR) && reserved;
  wire          start    = (cs_r == C_IDLE) && cmd_valid_in && !refuse;
  wire          bad      = (cs_r == C_IDLE) && cmd_valid_in && refuse;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      cs_r    <= C_IDLE;
      div_r   <= 8'h00;
      tck_r   <= 1'h0;
      tms_r   <= 1'h1;
      tdi_r   <= 1'h1;
      taken_r <= 1'h0;
      fin_r   <= 1'h0;
      rcnt_r  <= 8'h00;
      len_r   <= 8'h00;
      kind_r  <= bsil_pkg::CMD_RESET;
      sh_r    <= '0;
    end else begin
      div_r <= tick ? 8'h00 : run ? div_r + 8'h01 : 8'h00;
      if (start) begin
        cs_r    <= C_RUN;
        kind_r  <= cmd_kind_in;
        len_r   <= cmd_len_in;
        sh_r    <= cmd_data_in;
        rcnt_r  <= 8'h00;
        fin_r   <= 1'h0;
        taken_r <= 1'h0;
        tms_r   <= (cmd_kind_in == bsil_pkg::CMD_RESET) ? 1'h1 : (st != bsil_pkg::TAP_RESET);
        tdi_r   <= cmd_data_in[0];
      end else if (rise) begin
        tck_r   <= 1'h1;
        taken_r <= in_shift;
        fin_r   <= last_rise;
        rcnt_r  <= cnt_rise ? rcnt_r + 8'h01 : rcnt_r;
      end else if (fall) begin
        // tdo from the previous falling edge is sampled late, past both synchronisers
        tck_r   <= 1'h0;
        sh_r    <= taken_r ? sh_in : sh_r;
        tdi_r   <= taken_r ? sh_in[0] : sh_r[0];
        tms_r   <= is_reset ? tms_rst : tms_nxt;
        cs_r    <= fin_r ? C_DONE : C_RUN;
      end else if (cs_r == C_DONE) begin
        cs_r <= C_IDLE;
      end
    end
  end

  // ****************************************
  // answer
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      rdy_r <= 1'h0;
      rv_r  <= 1'h0;
      re_r  <= 1'h0;
      rd_r  <= '0;
    end else begin
      rdy_r <= (cs_r == C_IDLE) && !start && !bad;
      rv_r  <= (cs_r == C_DONE) || bad;
      re_r  <= bad;
      rd_r  <= (cs_r == C_DONE) ? (sh_r >> (8'(DW) - len_r)) : rd_r;
    end
  end

  assign cmd_ready_out = rdy_r;
  assign rsp_valid_out = rv_r;
  assign rsp_err_out   = re_r;
  assign rsp_data_out  = rd_r;
  assign link.tck      = tck_r;
  assign link.tms      = tms_r;
  assign link.tdi      = tdi_r;

endmodule : bsil_ctl

//--- test/bsil_monitor.sv
// wire-level checks on the serial test link between the two ends
`timescale 1ns/1ps
module bsil_monitor (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rstn_in,
  // link wires
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  // ****************************************
  // helper: tms history at test clock rises
  // ****************************************
  logic       tck_q_r;
  logic [2:0] hi_cnt_r;
  logic [1:0] tms2_r;
  wire        tck_rise = tck && !tck_q_r;

  // count saturates so a long reset stretch never wraps back under five
  always_ff @(posedge clk_sys_in) begin
    tck_q_r <= tck;
    if (!rstn_in) begin
      hi_cnt_r <= 3'h5;
      tms2_r   <= 2'h3;
    end else if (tck_rise) begin
      hi_cnt_r <= !tms ? 3'h0 : ((hi_cnt_r == 3'h7) ? hi_cnt_r : hi_cnt_r + 3'h1);
      tms2_r   <= {tms2_r[0], tms};
    end
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  // ****************************************
  // properties
  // ****************************************
  property p_tdo_edge; ($changed(tdo) || $changed(tdo_oe)) |-> !tck; endproperty
  a_tdo_edge: assert property (p_tdo_edge) else $error("tdo moved while tck high");
  property p_ctl_edge; ($changed(tms) || $changed(tdi)) |-> !tck; endproperty
  a_ctl_edge: assert property (p_ctl_edge) else $error("tms or tdi moved while tck high");
  property p_tck_high; $rose(tck) |-> tck [*4] ##1 !tck; endproperty
  a_tck_high: assert property (p_tck_high) else $error("tck high phase not four clocks");
  property p_tck_low; $fell(tck) |-> !tck [*4]; endproperty
  a_tck_low: assert property (p_tck_low) else $error("tck low phase too short");
  property p_rst_quiet; $rose(rstn_in) |-> !tdo_oe && !tdo && !tck && tms; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("link not quiet after reset");
  property p_reset5; (hi_cnt_r >= 3'h5) |-> !tdo_oe; endproperty
  a_reset5: assert property (p_reset5) else $error("tdo driven after five tms-high rises");
  property p_oe_rise; $rose(tdo_oe) |-> (tms2_r == 2'h0); endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("tdo enabled outside a shift state");
  property p_oe_fall; $fell(tdo_oe) |-> tms2_r[0]; endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("tdo released while still shifting");
endmodule : bsil_monitor

//--- test/tb_boundary_scan_instruction_logic.sv
// self-checking bench: controller and device joined over the test link
`timescale 1ns/1ps
module tb_boundary_scan_instruction_logic;
  localparam logic [31:0] ID_V = 32'h5A3C_96E1; // arbitrary identification value
  logic                clk_sys_in = 1'b0;
  logic                rstn_in    = 1'b0;
  logic                cmd_valid  = 1'b0;
  bsil_pkg::bsil_cmd_t cmd_kind   = bsil_pkg::CMD_RESET;
  logic [7:0]          cmd_len    = 8'h00;
  logic [127:0]        cmd_data   = '0;
  logic [107:0]        pins       = '0;
  logic                cmd_ready, rsp_valid, rsp_err, extest, oe, res;
  logic [127:0]        rsp_data, d, cap;
  logic [107:0]        preload;
  logic [2:0]          instr, cur, c;
  logic [108:0]        latch;
  int                  n_errors = 0;
  int                  samples_checked = 0;
  int                  len_reg;

  bsil_if link ();
  always #20 clk_sys_in = ~clk_sys_in;

  bsil_ctl #(.HALF_CYC(4), .DW(128)) bsil_ctl_i (.clk_sys_in, .rstn_in, .cmd_valid_in(cmd_valid),
    .cmd_kind_in(cmd_kind), .cmd_len_in(cmd_len), .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready),
    .rsp_valid_out(rsp_valid), .rsp_err_out(rsp_err), .rsp_data_out(rsp_data), .link(link.ctl));
  bsil_dev #(.ID_VALUE(ID_V)) bsil_dev_i (.clk_sys_in, .rstn_in, .link(link.dev), .pin_levels_in(pins),
    .preload_out(preload), .extest_drive_out(extest), .out_bus_oe_out(oe), .instr_out(instr));
  bsil_monitor bsil_monitor_i (.clk_sys_in, .rstn_in, .tck(link.tck), .tms(link.tms), .tdi(link.tdi),
    .tdo(link.tdo), .tdo_oe(link.tdo_oe));

  // ****************************************
  // compare and report
  // ****************************************
  task automatic chk_data(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_st(input logic [5:0] got, input logic [5:0] exp);
    chk_data(128'(got), 128'(exp));
  endtask : chk_st

  task automatic check_all(input logic e);
    logic oe_exp;
    // sample-high-Z floats the outputs, external test hands them to cell 108
    oe_exp = (cur == 3'h2) ? 1'h0 : ((cur == 3'h0) ? latch[108] : 1'h1);
    chk_st({rsp_err, instr, oe, extest}, {e, cur, oe_exp, cur == 3'h0});
    chk_data(128'(preload), 128'(latch[107:0]));
  endtask : check_all

  task automatic report_and_stop();
    $display("checked=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // expected serial output: the selected register is a queue, captured bits ahead of the bits shifted in
  function automatic logic [127:0] shifted(input int l, input logic [127:0] cp, input logic [127:0] dt,
                                           input int len);
    logic         q[$];
    logic [127:0] r;
    r = '0;
    for (int k = 0; k < l; k++) q.push_back(cp[k]);
    for (int k = 0; k < len; k++) begin
      q.push_back(dt[k]);
      r[k] = q.pop_front();
    end
    return r;
  endfunction : shifted

  // called at a falling edge; returns at the falling edge that shows the answer
  task automatic scan(input bsil_pkg::bsil_cmd_t k, input logic [7:0] len, input logic [127:0] dt);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= 100) n_errors++;
    cmd_valid = 1'b1;
    cmd_kind  = k;
    cmd_len   = len;
    cmd_data  = dt;
    @(negedge clk_sys_in);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= 4000) n_errors++;
    // the answer pulse stands alone: ready only returns the cycle after it
    chk_st({4'h0, rsp_valid, cmd_ready}, 6'h2);
  endtask : scan

  task automatic hard_reset();
    rstn_in = 1'b0;
    repeat (5) @(negedge clk_sys_in);
    rstn_in = 1'b1;
    latch = {1'b1, 108'h0};
    cur = 3'h1;
    repeat (4) @(negedge clk_sys_in);
    check_all(1'b0);
  endtask : hard_reset

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(33));
    @(negedge clk_sys_in);
    hard_reset();
    scan(bsil_pkg::CMD_RESET, 8'h00, '0);
    check_all(1'b0);
    for (int i = 0; i < 16; i++) begin
      c = i[2:0];
      res = (c == 3'h3) || (c == 3'h5) || (c == 3'h6);
      scan(bsil_pkg::CMD_IR, 8'h03, {125'h0, c});
      if (!res) chk_data(rsp_data, 128'h1);
      if (!res) cur = c;
      check_all(res);
      pins = 108'({$urandom(), $urandom(), $urandom(), $urandom()});
      d = {$urandom(), $urandom(), $urandom(), $urandom()};
      len_reg = (cur == 3'h1) ? 32 : ((cur == 3'h7) ? 1 : 109);
      cap = (cur == 3'h1) ? 128'(ID_V) : ((cur == 3'h7) ? 128'h0 : 128'({latch[108], pins}));
      scan(bsil_pkg::CMD_DR, 8'd109, d);
      chk_data(rsp_data, shifted(len_reg, cap, d, 109));
      if (len_reg == 109) latch = d[108:0];
      check_all(1'b0);
    end
    scan(bsil_pkg::CMD_RESET, 8'h00, '0);
    latch[108] = 1'b1;
    cur = 3'h1;
    check_all(1'b0);
    scan(bsil_pkg::CMD_IR, 8'h03, 128'h0);
    cur = 3'h0;
    check_all(1'b0);
    hard_reset();
    report_and_stop();
  end

  // cut a hang short well past the expected run length
  initial begin
    #3_000_000;
    n_errors++;
    report_and_stop();
  end
endmodule : tb_boundary_scan_instruction_logic
